// ==== hw/ppscr_pkg.sv ====
// Purpose: Shared constants and types for the port status and control regs.
// Assumes: A 25 MHz device clock.
// Notes: All bit positions, codes and timing counts live here.
package ppscr_pkg;
    localparam int CLK_KHZ = 25000;
    // Fast blink period in ms is the clock figure in Hz times 0.00013.
    localparam int BLINK_PERIOD_MS = CLK_KHZ * 13 / 100;
    localparam int BLINK_HALF_CYC_DEF = BLINK_PERIOD_MS * CLK_KHZ / 2;
    localparam int BLINK_W = 26;
    localparam int POR_TIME_US = 10;
    localparam int POR_CYC = POR_TIME_US * CLK_KHZ / 1000;
    localparam int POR_W = 8;
    localparam logic [6:0] CHIP_ADDR = 7'h2A;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_PORT_CTRL = 3'h2;
    localparam logic [2:0] PORT_ONE = 3'h0;
    localparam logic [2:0] PORT_TWO = 3'h1;
    localparam logic [2:0] PORT_THREE = 3'h2;
    localparam int SEL_REG_LSB = 3;
    localparam int CTL_FAULT_DIS = 7;
    localparam int CTL_POR_DIS = 6;
    localparam int CTL_SW_RESET = 5;
    localparam int CTL_CLASS_LIM = 5;
    localparam int CTL_BLINK = 4;
    localparam int CTL_LED_LOW = 3;
    localparam int CTL_LED_HIGH = 2;
    localparam logic [3:0] STAT_SPARE = 4'h7;
    localparam logic [7:0] RD_UNMAPPED = 8'hFF;
    localparam logic [7:0] CLASS_MA_MAX = 8'hA0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_AACK = 9'h004,
        S_SEL = 9'h008,
        S_SACK = 9'h010,
        S_WDAT = 9'h020,
        S_WACK = 9'h040,
        S_RDAT = 9'h080,
        S_RACK = 9'h100
    } ppscr_fsm_e;

    typedef struct packed {
        logic timer_en;
        logic [1:0] mode;
        logic led_low;
        logic led_high;
    } ppscr_port_s;

    typedef struct packed {
        ppscr_fsm_e fsm;
        logic scl1, scl2, sclp, sda1, sda2, sdap;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] sel;
        logic rw;
        logic [1:0][7:0] ctl;
        logic cl_hi;
        logic [BLINK_W-1:0] blink_cnt;
        logic blink_ph;
        logic [POR_W-1:0] por_cnt;
    } ppscr_state_s;

    localparam ppscr_state_s RST_ST = '{fsm: S_IDLE, scl1: 1'b1,
        scl2: 1'b1, sclp: 1'b1, sda1: 1'b1, sda2: 1'b1, sdap: 1'b1,
        cnt: 4'h0, sh: 8'h00, sel: 8'h00, rw: 1'b0, ctl: 16'h0000,
        cl_hi: 1'b0, blink_cnt: '0, blink_ph: 1'b0,
        por_cnt: POR_W'(POR_CYC)};
endpackage : ppscr_pkg

// ==== hw/ppscr_regs.sv ====
// Purpose: Port status and control registers behind a two-wire serial port.
// Assumes: Status inputs come from logic on REF_CLK_I; bus pins do not.
// Notes: The rules that the logic below keeps are listed here.
// Contract
// - Status bit 7 is 1 only while the sequencer is servicing that port.
// - Status bits 2:0 return the port's 3-bit fault code.
// - Control bit 7 set disables the port's overload and voltage timers.
// - Port 1 control bit 6 set holds the power-on reset out of reset.
// - Port 1 control bit 5 set resets all but the bus input synchronizers and restarts POR timing.
// - Control bit 4 makes the enabled LED blink, else it is steady.
// - The blink period is counted in device clock cycles.
// - Control bit 3 turns on the low-side LED driver.
// - Control bit 2 turns on the high-side LED driver.
// - Control bits 1:0 select off, power-up, sample or power-down.
// - Two common bits choose a 160, 80, 40 or 20 mA class limit.
// - Common bits act on the whole device, not the addressed port.
// - A data byte after a port 1 or 2 control select is latched, after port 3 only its bit 5; every data byte is acknowledged.
// - The high class-limit bit comes from port 3 control bit 5.
`timescale 1ns/1ns
module ppscr_regs
    import ppscr_pkg::*;
#(
    parameter int BLINK_HALF_CYC = BLINK_HALF_CYC_DEF
)(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    input wire logic SVC_ACTIVE_I,
    input wire logic [2:0] SVC_PORT_I,
    input wire logic [7:0][2:0] FAULT_CODE_I,
    output ppscr_port_s [1:0] PORT_O,
    output logic [7:0] CLASS_MA_O,
    output logic POR_READY_O
);
    ppscr_state_s r_ff;
    ppscr_state_s nxt_r;
    logic rise, fall, start, stop;

    // Builds the byte that a read returns for the latched select.
    function automatic logic [7:0] rd_byte(input logic [7:0] sel,
        input logic act, input logic [2:0] port,
        input logic [7:0][2:0] flt);
        logic [7:0] b;
        b = RD_UNMAPPED;
        if (sel[SEL_REG_LSB +: 3] == REG_STATUS)
        begin
            b = {act && (port == sel[2:0]), STAT_SPARE, flt[sel[2:0]]};
        end
        return b;
    endfunction : rd_byte

    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.scl1 = SCL_I;
        nxt_r.scl2 = r_ff.scl1;
        nxt_r.sclp = r_ff.scl2;
        nxt_r.sda1 = SDA_I;
        nxt_r.sda2 = r_ff.sda1;
        nxt_r.sdap = r_ff.sda2;
        rise = r_ff.scl2 && !r_ff.sclp;
        fall = !r_ff.scl2 && r_ff.sclp;
        start = r_ff.scl2 && r_ff.sclp && r_ff.sdap && !r_ff.sda2;
        stop = r_ff.scl2 && r_ff.sclp && !r_ff.sdap && r_ff.sda2;
        unique case (r_ff.fsm)
            S_IDLE:
            begin
                nxt_r.cnt = 4'h0;
            end
            S_ADDR, S_SEL, S_WDAT:
            begin
                if (rise)
                begin
                    nxt_r.sh = {r_ff.sh[6:0], r_ff.sda2};
                    nxt_r.cnt = r_ff.cnt + 4'h1;
                end
                if (fall && r_ff.cnt == BYTE_BITS)
                begin
                    nxt_r.cnt = 4'h0;
                    if (r_ff.fsm == S_ADDR)
                    begin
                        nxt_r.rw = r_ff.sh[0];
                        nxt_r.fsm = (r_ff.sh[7:1] == CHIP_ADDR) ? S_AACK
                            : S_IDLE;
                    end
                    else if (r_ff.fsm == S_SEL)
                    begin
                        nxt_r.sel = r_ff.sh;
                        nxt_r.fsm = S_SACK;
                    end
                    else
                    begin
                        nxt_r.fsm = S_WACK;
                        if (r_ff.sel[SEL_REG_LSB +: 3] == REG_PORT_CTRL)
                        begin
                            if (r_ff.sel[2:0] == PORT_ONE)
                            begin
                                nxt_r.ctl[0] = r_ff.sh;
                            end
                            if (r_ff.sel[2:0] == PORT_TWO)
                            begin
                                nxt_r.ctl[1] = r_ff.sh;
                            end
                            if (r_ff.sel[2:0] == PORT_THREE)
                            begin
                                nxt_r.cl_hi = r_ff.sh[CTL_CLASS_LIM];
                            end
                        end
                    end
                end
            end
            S_AACK:
            begin
                if (fall)
                begin
                    nxt_r.fsm = r_ff.rw ? S_RDAT : S_SEL;
                    nxt_r.sh = rd_byte(r_ff.sel, SVC_ACTIVE_I, SVC_PORT_I,
                        FAULT_CODE_I);
                end
            end
            S_SACK:
            begin
                if (fall)
                begin
                    nxt_r.fsm = S_WDAT;
                end
            end
            S_WACK, S_RACK:
            begin
                if (fall)
                begin
                    nxt_r.fsm = S_IDLE;
                end
            end
            S_RDAT:
            begin
                if (fall)
                begin
                    nxt_r.sh = {r_ff.sh[6:0], 1'b1};
                    nxt_r.cnt = r_ff.cnt + 4'h1;
                    if (r_ff.cnt == LAST_BIT)
                    begin
                        nxt_r.fsm = S_RACK;
                    end
                end
            end
            default:
            begin
                nxt_r.fsm = S_IDLE;
            end
        endcase
        if (start)
        begin
            nxt_r.fsm = S_ADDR;
            nxt_r.cnt = 4'h0;
        end
        else if (stop)
        begin
            nxt_r.fsm = S_IDLE;
        end
        if (r_ff.blink_cnt == BLINK_W'(BLINK_HALF_CYC - 1))
        begin
            nxt_r.blink_cnt = '0;
            nxt_r.blink_ph = !r_ff.blink_ph;
        end
        else
        begin
            nxt_r.blink_cnt = r_ff.blink_cnt + BLINK_W'(1);
        end
        if (r_ff.por_cnt != '0)
        begin
            nxt_r.por_cnt = r_ff.por_cnt - POR_W'(1);
        end
        // self clearing
        // The reset waits out the data acknowledge, so the host sees it.
        if (r_ff.ctl[0][CTL_SW_RESET] && r_ff.fsm != S_WACK)
        begin
            nxt_r = RST_ST;
            nxt_r.scl1 = SCL_I;
            nxt_r.scl2 = r_ff.scl1;
            nxt_r.sclp = r_ff.scl2;
            nxt_r.sda1 = SDA_I;
            nxt_r.sda2 = r_ff.sda1;
            nxt_r.sdap = r_ff.sda2;
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RSTN_I)
        begin
            r_ff <= RST_ST;
        end
        else if (CE_I)
        begin
            r_ff <= nxt_r;
        end
    end

    assign SDA_O = 1'b0;
    assign SDA_OE_N_O = !(r_ff.fsm inside {S_AACK, S_SACK, S_WACK}
        || (r_ff.fsm == S_RDAT && !r_ff.sh[7]));

    assign POR_READY_O = r_ff.ctl[0][CTL_POR_DIS] || (r_ff.por_cnt == '0);
    assign CLASS_MA_O = CLASS_MA_MAX
        >> {r_ff.cl_hi, r_ff.ctl[1][CTL_CLASS_LIM]};

    for (genvar p = 0; p < 2; p++)
    begin : g_port
        assign PORT_O[p].timer_en = !r_ff.ctl[p][CTL_FAULT_DIS];
        assign PORT_O[p].mode = r_ff.ctl[p][1:0];
        assign PORT_O[p].led_low = r_ff.ctl[p][CTL_LED_LOW]
            && (!r_ff.ctl[p][CTL_BLINK] || r_ff.blink_ph);
        assign PORT_O[p].led_high = r_ff.ctl[p][CTL_LED_HIGH]
            && (!r_ff.ctl[p][CTL_BLINK] || r_ff.blink_ph);
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);

    status_service_a: assert property (
        CE_I && r_ff.fsm == S_AACK && fall && r_ff.rw
        && r_ff.sel[5:3] == REG_STATUS |=> r_ff.sh[7] ==
        ($past(SVC_ACTIVE_I) && $past(SVC_PORT_I) == r_ff.sel[2:0]))
        else $error("Service bit does not match sequencer.");
    status_fault_a: assert property (
        CE_I && r_ff.fsm == S_AACK && fall && r_ff.rw
        && r_ff.sel[5:3] == REG_STATUS |=> r_ff.sh[2:0] ==
        $past(FAULT_CODE_I[r_ff.sel[2:0]]))
        else $error("Fault code read back wrong.");
    status_spare_a: assert property (
        CE_I && r_ff.fsm == S_AACK && fall && r_ff.rw
        && r_ff.sel[5:3] == REG_STATUS |=> r_ff.sh[6:3] == STAT_SPARE)
        else $error("Status spare bits wrong.");
    write_latch_a: assert property (
        CE_I && r_ff.fsm == S_WDAT && fall && r_ff.cnt == BYTE_BITS
        && r_ff.sel == {2'b00, REG_PORT_CTRL, PORT_TWO} && !r_ff.ctl[0][5]
        |=> r_ff.ctl[1] == $past(r_ff.sh) && !SDA_OE_N_O)
        else $error("Control byte not latched and acknowledged.");
    sw_reset_a: assert property (
        CE_I && r_ff.ctl[0][CTL_SW_RESET] && r_ff.fsm != S_WACK
        |=> r_ff.ctl == 16'h0000
        && r_ff.por_cnt == POR_W'(POR_CYC) && !POR_READY_O)
        else $error("Software reset did not restart POR timing.");
    por_hold_a: assert property (
        r_ff.ctl[0][CTL_POR_DIS] |-> POR_READY_O)
        else $error("POR not forced to non-reset state.");
    class_map_a: assert property (
        CE_I && r_ff.fsm == S_WDAT && fall && r_ff.cnt == BYTE_BITS
        && r_ff.sel == {2'b00, REG_PORT_CTRL, PORT_THREE}
        && !r_ff.ctl[0][5] |=> ##1 CLASS_MA_O ==
        (CLASS_MA_MAX >> {$past(r_ff.sh[5], 2), r_ff.ctl[1][5]}))
        else $error("Class limit from wrong bits.");
    blink_steady_a: assert property (
        !r_ff.ctl[0][CTL_BLINK] && r_ff.ctl[0][CTL_LED_LOW]
        |-> PORT_O[0].led_low && PORT_O[0].timer_en
        == !r_ff.ctl[0][CTL_FAULT_DIS])
        else $error("Steady LED or timer enable wrong.");
    blink_toggle_a: assert property (
        CE_I && r_ff.blink_cnt == BLINK_W'(BLINK_HALF_CYC - 1)
        && !r_ff.ctl[0][5] |=> r_ff.blink_ph != $past(r_ff.blink_ph)
        && r_ff.blink_cnt == '0)
        else $error("Blink phase did not toggle at period end.");
endmodule : ppscr_regs

// ==== tb/ppscr_host.sv ====
// Purpose: Serial bus master model for the register port.
// Assumes: Open-drain data line with a pull-up.
// Notes: Each bus phase lasts HP device clock cycles.
`timescale 1ns/1ns
module ppscr_host
    import ppscr_pkg::*;
#(
    parameter int HP = 16
)(
    input wire logic clk_i,
    input wire logic dev_oe_n_i,
    input wire logic dev_sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic drv_ff = 1'b1;
    initial scl_o = 1'b1;
    // The wire is low when either party pulls it.
    assign sda_o = drv_ff & (dev_oe_n_i | dev_sda_i);

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt

    task automatic start;
        drv_ff <= 1'b0;
        wt(HP);
        scl_o <= 1'b0;
    endtask : start

    task automatic stop;
        wt(HP / 2);
        drv_ff <= 1'b0;
        wt(HP / 2);
        scl_o <= 1'b1;
        wt(HP);
        drv_ff <= 1'b1;
        wt(HP);
    endtask : stop

    task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                        output logic ack);
        logic [8:0] o;
        logic [8:0] s;
        o = {d, 1'b1};
        for (int i = 8; i >= 0; i--)
        begin
            wt(HP / 2);
            drv_ff <= o[i];
            wt(HP / 2);
            scl_o <= 1'b1;
            wt(HP);
            s[i] = sda_o;
            scl_o <= 1'b0;
        end
        q = s[8:1];
        ack = s[0];
    endtask : xfer

    function automatic logic [7:0] sel(input logic [2:0] rg,
                                       input logic [2:0] pt);
        return {2'b00, rg, pt};
    endfunction : sel

    task automatic probe(input logic [6:0] a, output logic ack);
        logic [7:0] q;
        start();
        xfer({a, 1'b0}, q, ack);
        stop();
    endtask : probe

    task automatic wr(input logic [7:0] sl, input logic [7:0] d,
                      output logic [2:0] acks);
        logic [7:0] q;
        start();
        xfer({CHIP_ADDR, 1'b0}, q, acks[2]);
        xfer(sl, q, acks[1]);
        xfer(d, q, acks[0]);
        stop();
    endtask : wr

    task automatic rd(input logic [7:0] sl, output logic [7:0] d,
                      output logic [2:0] acks);
        logic nak;
        start();
        xfer({CHIP_ADDR, 1'b0}, d, acks[2]);
        xfer(sl, d, acks[1]);
        stop();
        start();
        xfer({CHIP_ADDR, 1'b1}, d, acks[0]);
        // The master closes the read by leaving the line high.
        xfer(8'hFF, d, nak);
        stop();
    endtask : rd
endmodule : ppscr_host

// ==== tb/ppscr_regs_test.sv ====
// Purpose: Self-checking bench for the port status and control regs.
// Assumes: Blink half period shortened to HALF cycles.
// Notes: Bus traffic comes from the ppscr_host model.
`timescale 1ns/1ns
module ppscr_regs_test;
    import ppscr_pkg::*;
    localparam int HALF = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic svc_act = 1'b0;
    logic [2:0] svc_port = 3'h0;
    logic [7:0][2:0] flt = '0;
    logic scl;
    logic sda;
    logic oe_n;
    logic dev_sda;
    logic ce = 1'b1;
    ppscr_port_s [1:0] port;
    logic [7:0] class_ma;
    logic por_rdy;
    logic [7:0] d;
    logic [2:0] acks;
    logic [2:0] p;
    logic a;
    int err_total = 0;
    int check_count = 0;
    int g;

    initial
    begin
        forever #20 clk = ~clk;
    end

    ppscr_regs #(.BLINK_HALF_CYC(HALF)) dut (
        .REF_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .SCL_I(scl),
        .SDA_I(sda), .SDA_O(dev_sda), .SDA_OE_N_O(oe_n),
        .SVC_ACTIVE_I(svc_act),
        .SVC_PORT_I(svc_port), .FAULT_CODE_I(flt), .PORT_O(port),
        .CLASS_MA_O(class_ma), .POR_READY_O(por_rdy));
    ppscr_host #(.HP(16)) host (.clk_i(clk), .dev_oe_n_i(oe_n),
        .dev_sda_i(dev_sda), .scl_o(scl), .sda_o(sda));

    function automatic logic [7:0] exp_stat(input logic [2:0] pt);
        return {svc_act && svc_port == pt, 1'b0, 3'b111, flt[pt]};
    endfunction : exp_stat

    function automatic logic [7:0] exp_port(input logic [7:0] v);
        return {3'h0, ~v[7], v[1:0], v[3], v[2]};
    endfunction : exp_port

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic wrc(input logic [2:0] pt, input logic [7:0] v);
        host.wr(host.sel(REG_PORT_CTRL, pt), v, acks);
        check(8'(acks), 8'h00);
    endtask : wrc

    // Measures the spacing of the last two rises of the port 1 LED.
    task automatic blink_gap(output int gap);
        logic prev;
        int t0;
        prev = 1'b1;
        t0 = 0;
        gap = 0;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge clk);
            #1;
            if (port[0].led_low === 1'b1 && prev === 1'b0)
            begin
                gap = n - t0;
                t0 = n;
            end
            prev = port[0].led_low;
        end
    endtask : blink_gap

    initial
    begin
        repeat (90000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial
    begin
        void'($urandom(41313));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        check(8'(por_rdy), 8'h00);
        check(class_ma, 8'hA0);
        repeat (POR_CYC + 5) @(posedge clk);
        check(8'(por_rdy), 8'h01);
        host.probe(CHIP_ADDR ^ 7'h01, a);
        check(8'(a), 8'h01);
        for (int i = 0; i < 10; i++)
        begin
            p = 3'($urandom);
            flt <= 24'($urandom);
            svc_act <= (i < 3) | 1'($urandom);
            svc_port <= (i < 2) ? p : 3'($urandom);
            @(posedge clk);
            host.rd(host.sel(REG_STATUS, p), d, acks);
            check(d, exp_stat(p));
            check(8'(acks), 8'h00);
        end
        host.rd(host.sel(3'h3, 3'h0), d, acks);
        check(d, 8'hFF);
        for (int i = 0; i < 12; i++)
        begin
            d = 8'($urandom);
            d[1:0] = i[2:1];
            d[4] = 1'b0;
            d[6:5] = d[6:5] & {2{i[0]}};
            wrc(3'(i[0]), d);
            check(8'(port[i[0]]), exp_port(d));
        end
        for (int k = 0; k < 4; k++)
        begin
            wrc(PORT_THREE, {2'b00, k[1], 5'h00});
            wrc(PORT_TWO, {2'b00, k[0], 5'h00});
            check(class_ma, 8'hA0 >> k);
        end
        wrc(PORT_ONE, 8'h18);
        blink_gap(g);
        check(8'(g), 8'(2 * HALF));
        // Twenty frozen cycles would otherwise flip the phase five times.
        @(posedge clk);
        ce <= 1'b0;
        #1;
        a = port[0].led_low;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        #1;
        check(8'(port[0].led_low), 8'(a));
        @(posedge clk);
        wrc(PORT_ONE, 8'h20);
        check(8'(por_rdy), 8'h00);
        check(class_ma, 8'hA0);
        check(8'(port[0]), exp_port(8'h00));
        repeat (POR_CYC + 5) @(posedge clk);
        check(8'(por_rdy), 8'h01);
        repeat (POR_CYC + 5) @(posedge clk);
        check(8'(por_rdy), 8'h01);
        wrc(PORT_ONE, 8'h40);
        check(8'(por_rdy), 8'h01);
        complete_run();
    end
endmodule : ppscr_regs_test
